/* core/pichst_defines.vh */
// Purpose: constants for the interrupt-controller host driver
// Assumes: clk_sys at 125 MHz
// Notes:   offsets are byte addresses of the AXI4-Lite registers
`ifndef PICHST_DEFINES_VH
`define PICHST_DEFINES_VH

`define PICHST_OFF_CMD      4'h0
`define PICHST_OFF_STATUS   4'h4
`define PICHST_OFF_RDATA    4'h8
`define PICHST_OFF_VECTOR   4'hC

`define PICHST_OP_WRITE     2'h0
`define PICHST_OP_READ      2'h1
`define PICHST_OP_ACK       2'h2

`define PICHST_CMD_DATA_LSB 0
`define PICHST_CMD_SEL_BIT  8
`define PICHST_CMD_OP_LSB   16
`define PICHST_CMD_MODE_BIT 20

`define PICHST_CALL_OPCODE  8'hCD

// Strobe width in ns and in cycles, a least time rounded up
`define PICHST_STROBE_NS    420
`define PICHST_STROBE_CYC   ((`PICHST_STROBE_NS * 125 + 999) / 1000)
// Gap after a strobe in ns and in cycles
`define PICHST_GAP_NS       190
`define PICHST_GAP_CYC      ((`PICHST_GAP_NS * 125 + 999) / 1000)
`define PICHST_CNT_W        7

`endif

/* core/pichst_host.v */
// Purpose: host-side driver of an eight-level vectored interrupt controller
// Assumes: device pins are asynchronous; orders arrive over AXI4-Lite
// Notes:   one pin cycle at a time; status polled by software
`timescale 1ns/1ps
`include "pichst_defines.vh"

module pichst_host
(
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         chip_select_n,
    output reg         write_n,
    output reg         read_n,
    output reg         irq_acknowledge_n,
    output reg         word_select,
    input  wire [7:0]  host_data_bus_in,
    output reg  [7:0]  host_data_bus_out,
    output reg         host_data_bus_oe_n,
    input  wire        device_irq
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [7:0] data_meta;
    reg [7:0] data_sync;
    reg       irq_meta;
    reg       irq_sync;

    always @(posedge clk_sys)
    begin
        data_meta <= host_data_bus_in;
        data_sync <= data_meta;
        irq_meta  <= device_irq;
        irq_sync  <= irq_meta;
    end

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    localparam ST_IDLE   = 2'h0;
    localparam ST_STROBE = 2'h1;
    localparam ST_GAP    = 2'h2;

    reg [1:0]              state;
    reg [`PICHST_CNT_W-1:0] count;
    reg [1:0]              op;
    reg                    mode16;
    reg [1:0]              ack_idx;
    reg [7:0]              read_byte;
    reg [23:0]             vector_bytes;
    reg                    busy;
    reg                    cmd_error;

    // Timing counts cut to the counter width on purpose
    wire [31:0]              strobe_cyc_full = `PICHST_STROBE_CYC;
    wire [31:0]              gap_cyc_full    = `PICHST_GAP_CYC;
    wire [`PICHST_CNT_W-1:0] strobe_cyc      = strobe_cyc_full[`PICHST_CNT_W-1:0];
    wire [`PICHST_CNT_W-1:0] gap_cyc         = gap_cyc_full[`PICHST_CNT_W-1:0];

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire cmd_hit = wr_fire && (s_axi_awaddr == `PICHST_OFF_CMD);
    wire start   = cmd_hit && !busy;

    // Address and data are taken together, so neither is accepted without the other
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h00000000;
        end
        else
        begin
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                // Busy or unmapped writes answer slave error
                s_axi_bresp  <= (start && s_axi_wdata[`PICHST_CMD_OP_LSB+1:`PICHST_CMD_OP_LSB]
                                 != 2'h3) ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `PICHST_OFF_STATUS: s_axi_rdata <= {29'h0, cmd_error, irq_sync, busy};
                    `PICHST_OFF_RDATA:  s_axi_rdata <= {24'h0, read_byte};
                    `PICHST_OFF_VECTOR: s_axi_rdata <= {8'h0, vector_bytes};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pin cycle engine
    // ----------------------------------------
    // Acknowledge pulses per sequence: three in 8-bit mode, two in 16-bit
    wire [1:0] ack_last = mode16 ? 2'h1 : 2'h2;

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            state              <= ST_IDLE;
            count              <= {`PICHST_CNT_W{1'b0}};
            op                 <= 2'h0;
            mode16             <= 1'b0;
            ack_idx            <= 2'h0;
            read_byte          <= 8'h00;
            vector_bytes       <= 24'h000000;
            busy               <= 1'b0;
            cmd_error          <= 1'b0;
            chip_select_n      <= 1'b1;
            write_n            <= 1'b1;
            read_n             <= 1'b1;
            irq_acknowledge_n  <= 1'b1;
            word_select        <= 1'b0;
            host_data_bus_out  <= 8'h00;
            host_data_bus_oe_n <= 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        op        <= s_axi_wdata[`PICHST_CMD_OP_LSB+1:`PICHST_CMD_OP_LSB];
                        mode16    <= s_axi_wdata[`PICHST_CMD_MODE_BIT];
                        ack_idx   <= 2'h0;
                        cmd_error <= 1'b0;
                        count     <= strobe_cyc;
                        case (s_axi_wdata[`PICHST_CMD_OP_LSB+1:`PICHST_CMD_OP_LSB])
                            `PICHST_OP_WRITE:
                            begin
                                busy               <= 1'b1;
                                state              <= ST_STROBE;
                                chip_select_n      <= 1'b0;
                                write_n            <= 1'b0;
                                word_select        <= s_axi_wdata[`PICHST_CMD_SEL_BIT];
                                host_data_bus_out  <= s_axi_wdata[7:0];
                                host_data_bus_oe_n <= 1'b0;
                            end
                            `PICHST_OP_READ:
                            begin
                                busy          <= 1'b1;
                                state         <= ST_STROBE;
                                chip_select_n <= 1'b0;
                                read_n        <= 1'b0;
                                word_select   <= s_axi_wdata[`PICHST_CMD_SEL_BIT];
                            end
                            `PICHST_OP_ACK:
                            begin
                                busy              <= 1'b1;
                                state             <= ST_STROBE;
                                vector_bytes      <= 24'h000000;
                                irq_acknowledge_n <= 1'b0;
                            end
                            default:
                                cmd_error <= 1'b1;
                        endcase
                    end
                end
                ST_STROBE:
                begin
                    if (count != {`PICHST_CNT_W{1'b0}})
                        count <= count - 1'b1;
                    else
                    begin
                        if (op == `PICHST_OP_READ)
                            read_byte <= data_sync;
                        if (op == `PICHST_OP_ACK)
                        begin
                            case (ack_idx)
                                2'h0:    vector_bytes[7:0]   <= mode16 ? 8'h00 : data_sync;
                                2'h1:    vector_bytes[15:8]  <= data_sync;
                                default: vector_bytes[23:16] <= data_sync;
                            endcase
                            if (!mode16 && ack_idx == 2'h0 && data_sync != `PICHST_CALL_OPCODE)
                                cmd_error <= 1'b1;
                        end
                        // Data released one cycle after strobe end, in ST_GAP, keeps write hold time
                        chip_select_n     <= 1'b1;
                        write_n           <= 1'b1;
                        read_n            <= 1'b1;
                        irq_acknowledge_n <= 1'b1;
                        count             <= gap_cyc;
                        state             <= ST_GAP;
                    end
                end
                ST_GAP:
                begin
                    host_data_bus_oe_n <= 1'b1;
                    if (count != {`PICHST_CNT_W{1'b0}})
                        count <= count - 1'b1;
                    else if (op == `PICHST_OP_ACK && ack_idx != ack_last)
                    begin
                        ack_idx           <= ack_idx + 2'h1;
                        irq_acknowledge_n <= 1'b0;
                        count             <= strobe_cyc;
                        state             <= ST_STROBE;
                    end
                    else
                    begin
                        busy  <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

endmodule

/* sim/pichst_props.sv */
// Purpose: pin strobe and bus timing checks
// Assumes: strobe low 54 cycles, gap 25 cycles
// Notes:   sees top ports only
`timescale 1ns/1ps
module pichst_props
(
    input wire       clk_sys,
    input wire       reset,
    input wire       chip_select_n,
    input wire       write_n,
    input wire       read_n,
    input wire       irq_acknowledge_n,
    input wire       host_data_bus_oe_n
);
    // ----
    // Helpers
    // ----
    wire      strobe = !write_n || !read_n || !irq_acknowledge_n;
    reg [6:0] low_cnt;
    reg [6:0] gap_cnt;
    always @(posedge clk_sys)
    begin
        low_cnt <= (reset || !strobe) ? 7'h00 : low_cnt + 7'h01;
        gap_cnt <= (reset || (!strobe && gap_cnt == 7'h7F)) ? 7'h7F :
                   (strobe ? 7'h00 : gap_cnt + 7'h01);
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_bus_release;
        !host_data_bus_oe_n ##1 host_data_bus_oe_n;
    endsequence
    a_write_select: assert property (!write_n |-> !chip_select_n)
        else $error("write strobe without select");
    a_read_select: assert property (!read_n |-> !chip_select_n)
        else $error("read strobe without select");
    a_ack_unselected: assert property (!irq_acknowledge_n |-> chip_select_n)
        else $error("acknowledge with select low");
    a_write_drives: assert property (!write_n |-> !host_data_bus_oe_n)
        else $error("write without data drive");
    a_read_floats: assert property (!read_n || !irq_acknowledge_n |-> host_data_bus_oe_n)
        else $error("bus driven during read");
    a_one_strobe: assert property ($onehot0({!write_n, !read_n, !irq_acknowledge_n}))
        else $error("two strobes at once");
    a_strobe_width: assert property ($fell(strobe) |-> low_cnt == 7'h36)
        else $error("strobe width wrong");
    a_strobe_gap: assert property ($rose(strobe) |-> gap_cnt >= 7'h19)
        else $error("gap between strobes short");
    a_data_hold: assert property ($rose(write_n) |-> s_bus_release)
        else $error("data not held past write");
endmodule
bind pichst_host pichst_props i_props
(
    .clk_sys(clk_sys), .reset(reset), .chip_select_n(chip_select_n),
    .write_n(write_n), .read_n(read_n), .irq_acknowledge_n(irq_acknowledge_n),
    .host_data_bus_oe_n(host_data_bus_oe_n)
);

/* sim/pichst_dev_model.sv */
// Purpose: behavioural interrupt controller device
// Assumes: asynchronous pins, released bus shows inverse
// Notes:   bad_call gives a wrong first byte on acknowledge
`timescale 1ns/1ps
module pichst_dev_model
(
    input  wire       chip_select_n,
    input  wire       write_n,
    input  wire       read_n,
    input  wire       irq_acknowledge_n,
    input  wire       word_select,
    input  wire [7:0] host_data_bus_out,
    input  wire [7:0] req,
    input  wire       mode16,
    input  wire       bad_call,
    output wire [7:0] host_data_bus_in,
    output wire       device_irq
);
    reg  [7:0] pend = 8'h00;
    reg  [7:0] insvc = 8'h00;
    reg  [7:0] mask = 8'h00;
    reg  [7:0] dout = 8'h00;
    reg  [7:0] shown = 8'h00;
    reg  [2:0] lvl = 3'h7;
    integer    n = 0;
    integer    i;
    // pin strapped high reads as master
    wire       master_select_input = 1'b1;
    reg  [2:0] cascade_id_lines = 3'h0;
    wire       rd_on = !read_n && !chip_select_n;
    wire       drive = rd_on || (!irq_acknowledge_n && !(mode16 && n == 1));
    wire [7:0] val = rd_on ? (word_select ? mask : pend) : dout;
    assign device_irq = |(pend & ~mask);
    always @(req) pend = pend | req;
    always @(negedge write_n) #1 if (!chip_select_n && word_select) mask = host_data_bus_out;
    always @* if (drive) shown = val;
    assign host_data_bus_in = drive ? val : ~shown;
    always @(negedge irq_acknowledge_n)
    begin
        n = n + 1;
        if (n == 1)
        begin
            lvl = 3'h7;
            for (i = 7; i >= 0; i = i - 1)
                if (pend[i] && !mask[i])
                    lvl = i[2:0];
            insvc[lvl] = 1'b1;
            pend[lvl] = 1'b0;
            if (master_select_input)
                cascade_id_lines = lvl;
            dout = bad_call ? 8'hC9 : 8'hCD;
        end
        else
            dout = (n == 2) ? {5'h08, lvl} : 8'h12;
    end
    always @(posedge irq_acknowledge_n)
        if (n == (mode16 ? 2 : 3))
        begin
            n = 0;
            insvc = 8'h00;
        end
endmodule

/* sim/tb_top.sv */
// Purpose: self-checking bench of the host driver
// Assumes: device model on the pins
// Notes:   write strobes tied to all ones
`timescale 1ns/1ps
`include "pichst_defines.vh"
module tb_top;
    reg         clk_sys = 1'b0;
    reg         reset = 1'b1;
    reg  [3:0]  awaddr = 4'h0;
    reg  [3:0]  araddr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'b0;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    reg  [7:0]  req = 8'h00;
    reg         mode16 = 1'b0;
    reg         bad_call = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid;
    wire        cs_n, wr_n, rd_n, ack_n, wsel, oe_n, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  din, dout;
    integer     fail_count = 0;
    integer     compares = 0;
    reg  [31:0] d;
    reg  [1:0]  r;
    initial forever #4 clk_sys = ~clk_sys;
    pichst_host i_pichst_host
    (
        .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chip_select_n(cs_n), .write_n(wr_n), .read_n(rd_n), .irq_acknowledge_n(ack_n),
        .word_select(wsel), .host_data_bus_in(din), .host_data_bus_out(dout),
        .host_data_bus_oe_n(oe_n), .device_irq(irq)
    );
    pichst_dev_model u_dev
    (
        .chip_select_n(cs_n), .write_n(wr_n), .read_n(rd_n), .irq_acknowledge_n(ack_n),
        .word_select(wsel), .host_data_bus_out(dout), .req(req), .mode16(mode16),
        .bad_call(bad_call), .host_data_bus_in(din), .device_irq(irq)
    );
    task complete_run;
    begin
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
        compares = compares + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task axi_wr(input [3:0] a, input [31:0] v);
    begin
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge clk_sys);
        while (!awready) @(posedge clk_sys);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        @(posedge clk_sys);
        while (!bvalid) @(posedge clk_sys);
        r = bresp;
        bready <= 1'b0;
    end
    endtask
    task axi_rd(input [3:0] a);
    begin
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clk_sys);
        while (!arready) @(posedge clk_sys);
        arvalid <= 1'b0;
        rready <= 1'b1;
        @(posedge clk_sys);
        while (!rvalid) @(posedge clk_sys);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    end
    endtask
    task cmd(input [1:0] op, input sel, input [7:0] v, input m16);
    begin
        mode16 <= m16;
        axi_wr(`PICHST_OFF_CMD, {11'h0, m16, 2'h0, op, 7'h0, sel, v});
        chk("bresp", 32'h0, {30'h0, r});
        d = 32'h1;
        while (d[0]) axi_rd(`PICHST_OFF_STATUS);
    end
    endtask
    task t_mask;
    begin
        cmd(`PICHST_OP_WRITE, 1'b1, 8'h04, 1'b0);
        cmd(`PICHST_OP_READ, 1'b1, 8'h00, 1'b0);
        axi_rd(`PICHST_OFF_RDATA);
        chk("mask", 32'h04, {24'h0, d[7:0]});
    end
    endtask
    task t_pending;
    begin
        req <= 8'h24;
        repeat (10) @(posedge clk_sys);
        axi_rd(`PICHST_OFF_STATUS);
        chk("irq", 32'h1, {31'h0, d[1]});
        cmd(`PICHST_OP_READ, 1'b0, 8'h00, 1'b0);
        axi_rd(`PICHST_OFF_RDATA);
        chk("pending", 32'h24, {24'h0, d[7:0]});
    end
    endtask
    task t_acks;
    begin
        cmd(`PICHST_OP_ACK, 1'b0, 8'h00, 1'b0);
        axi_rd(`PICHST_OFF_VECTOR);
        chk("vec8", 32'h1245CD, {8'h0, d[23:0]});
        axi_rd(`PICHST_OFF_STATUS);
        chk("error", 32'h0, {31'h0, d[2]});
        cmd(`PICHST_OP_WRITE, 1'b1, 8'h00, 1'b0);
        cmd(`PICHST_OP_ACK, 1'b0, 8'h00, 1'b1);
        axi_rd(`PICHST_OFF_VECTOR);
        chk("vec16", 32'h4200, {16'h0, d[15:0]});
        bad_call <= 1'b1;
        cmd(`PICHST_OP_ACK, 1'b0, 8'h00, 1'b0);
        axi_rd(`PICHST_OFF_VECTOR);
        chk("vec7", 32'h1247, {16'h0, d[23:8]});
        chk("cascade", 32'h7, {29'h0, u_dev.cascade_id_lines});
        axi_rd(`PICHST_OFF_STATUS);
        chk("status", 32'h4, {29'h0, d[2:0]});
    end
    endtask
    task t_refuse;
    begin
        axi_wr(`PICHST_OFF_CMD, 32'h0003_0000);
        chk("badop", 32'h2, {30'h0, r});
        axi_wr(`PICHST_OFF_STATUS, 32'h0);
        chk("badaddr", 32'h2, {30'h0, r});
        axi_rd(`PICHST_OFF_CMD);
        chk("rresp", 32'h2, {30'h0, r});
        chk("rdzero", 32'h0, d);
        axi_wr(`PICHST_OFF_CMD, 32'h0000_0000);
        chk("bresp", 32'h0, {30'h0, r});
        axi_wr(`PICHST_OFF_CMD, 32'h0000_0000);
        chk("busywr", 32'h2, {30'h0, r});
        d = 32'h1;
        while (d[0]) axi_rd(`PICHST_OFF_STATUS);
    end
    endtask
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        fail_count = fail_count + 1;
        complete_run;
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_mask;
        t_pending;
        t_acks;
        t_refuse;
        complete_run;
    end
endmodule
